// [wake_pkg.sv]
package wake_pkg;
  localparam logic [7:0] addr_enable_first  = 8'hb0;
  localparam logic [7:0] addr_enable_second = 8'hb1;
  localparam logic [7:0] addr_status_first  = 8'hb2;
  localparam logic [7:0] addr_irq_mask      = 8'hb4;
  localparam logic [7:0] addr_off_delay     = 8'hb8;
  localparam logic [7:0] rst_enable_first   = 8'h00;
  localparam logic [7:0] rst_enable_second  = 8'h80;
  localparam logic [7:0] rst_status_first   = 8'h00;
  localparam logic [7:0] rst_irq_mask       = 8'h00;
  localparam logic [7:0] rst_off_delay      = 8'h00;
  localparam int bit_ring_a      = 0;
  localparam int bit_ring_b      = 1;
  localparam int bit_kbd_clock   = 2;
  localparam int bit_mouse_clock = 3;
  localparam int bit_group_a     = 4;
  localparam int bit_group_b     = 5;
  localparam int bit_infrared    = 6;
  localparam int bit_alarm       = 7;
  localparam int bit_off_enable  = 7;
  localparam int bit_power_off_delay_select_sel = 6;
  localparam logic [7:0] latched_mask = 8'hcf;
  localparam int clk_hz          = 40000000;
  localparam int step_ms         = 500;
  localparam int step_cycles     = clk_hz / 1000 * step_ms;
endpackage

// [wake_regs_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface wake_regs_if;
  logic [7:0] enable_first;
  logic [7:0] enable_second;
  logic [7:0] off_delay;
  logic       button;
  logic       delay_busy;
  logic       delay_done;
  modport regs (output enable_first, enable_second, off_delay, button, input delay_busy, delay_done);
  modport timer (input enable_first, enable_second, off_delay, button, output delay_busy, delay_done);
endinterface
`default_nettype wire

// [off_delay_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module off_delay_timer
  import wake_pkg::*;
#(
  parameter int step_count = step_cycles
) (
  input  wire logic   core_clk_in, // 40 MHz
  input  wire logic   sys_rst_in,  // Sync reset
  wake_regs_if.timer  ctl          // Shared settings
);
  logic [31:0] tick;
  logic [5:0]  steps;
  logic        busy;

  assign ctl.delay_busy = busy;

  // Delay is (setting + 1) half-second steps
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy  <= 1'b0;
      tick  <= 32'h0;
      steps <= 6'h0;
      ctl.delay_done <= 1'b0;
    end else begin
      ctl.delay_done <= 1'b0;
      if (!busy) begin
        if (ctl.button && ctl.enable_second[bit_off_enable] && ctl.enable_second[bit_power_off_delay_select_sel]) begin
          busy  <= 1'b1;
          tick  <= 32'h0;
          steps <= ctl.off_delay[5:0];
        end
      end else if (tick == 32'(step_count - 1)) begin
        tick <= 32'h0;
        if (steps == 6'h0) begin
          busy <= 1'b0;
          ctl.delay_done <= 1'b1;
        end else begin
          steps <= steps - 6'h1;
        end
      end else begin
        tick <= tick + 32'h1;
      end
    end
  end

  start_delay_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (!busy && ctl.button && ctl.enable_second[bit_off_enable] && ctl.enable_second[bit_power_off_delay_select_sel])
    |=> busy) else $error("off delay did not start");
endmodule // off_delay_timer
`default_nettype wire

// [soft_power_wake_events.sv]
// Summary of operation
// - An enable bit at one lets its source raise the power-on request and at zero blocks it.
// - First enable bits: 0,1 ring a/b, 2 keyboard clock, 3 mouse clock, 4,5 group irq a/b, 6 infrared, 7 alarm.
// - Bit 7 of the second enable register resets to one.
// - The status register shows which source had an event, whether its enable bit is set or not.
// - A status bit reads one once its event happened, zero if not since last cleared.
// - Bits 0 and 1 catch falling edges on the ring pins and clear on status read.
// - Bits 2 and 3 catch falling edges on keyboard and mouse clock pins and clear on status read.
// - Bit 6 catches a falling edge on the infrared receive pin and clears on status read.
// - Bit 7 latches the clock alarm signal and clears on status read.
// - Bits 4 and 5 follow the group interrupts directly and ignore reads.
// - With off enable and delay select set, a button press starts the programmable delay.
`timescale 1ns/10ps
`default_nettype none
module soft_power_wake_events
  import wake_pkg::*;
#(
  parameter int step_count = step_cycles
) (
  input  wire logic       core_clk_in,          // 40 MHz clock
  input  wire logic       sys_rst_in,           // Sync reset, active high
  input  wire logic [7:0] reg_addr_in,          // Register address
  input  wire logic [7:0] reg_wdata_in,         // Write data
  input  wire logic       reg_wr_in,            // Write strobe
  input  wire logic       reg_rd_in,            // Read strobe
  output logic      [7:0] reg_rdata_out,        // Read data, cycle after strobe
  input  wire logic       ring_event_a_in,      // Ring pin a
  input  wire logic       ring_event_b_in,      // Ring pin b
  input  wire logic       kbd_clock_event_in,   // Keyboard clock pin
  input  wire logic       mouse_clock_event_in, // Mouse clock pin
  input  wire logic       infrared_rx_event_in, // Infrared receive pin
  input  wire logic       clock_alarm_in,       // Internal alarm
  input  wire logic       group_irq_a_in,       // Internal group irq a
  input  wire logic       group_irq_b_in,       // Internal group irq b
  input  wire logic       power_button_in,      // Button pin
  output logic            power_up_request_n_out, // Active-low power on request
  output logic            off_delay_done_out,   // Pulse at end of delay
  output logic            irq_out               // Level interrupt
);
  wake_regs_if ctl ();

  logic [7:0] wake_enable_first;
  logic [7:0] wake_status_first;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic       button_meta;
  logic       button_sync;
  logic       button_prev;
  logic [7:0] next_latched;
  logic [7:0] status_view;
  logic       status_read;
  logic       irq_read;

  function automatic logic [7:0] pin_to_status(input logic [4:0] p);
    pin_to_status = {1'b0, p[4], 2'b00, p[3], p[2], p[1], p[0]};
  endfunction

  // Address compare shared by the write, read and clear paths
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = addr_hit(a, addr_enable_first) || addr_hit(a, addr_enable_second) || addr_hit(a, addr_status_first)
                  || addr_hit(a, addr_irq_mask) || addr_hit(a, addr_off_delay);
  endfunction

  assign status_read = reg_rd_in && addr_hit(reg_addr_in, addr_status_first);
  assign irq_read    = reg_rd_in && addr_hit(reg_addr_in, addr_status_first);

  // Pins come from outside; two stages before edge detection
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
      pin_prev <= 5'h1f;
    end else begin
      pin_meta <= {infrared_rx_event_in, mouse_clock_event_in, kbd_clock_event_in, ring_event_b_in, ring_event_a_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Button idles low, so its chain resets low to avoid a false press
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      button_meta <= 1'b0;
      button_sync <= 1'b0;
      button_prev <= 1'b0;
    end else begin
      button_meta <= power_button_in;
      button_sync <= button_meta;
      button_prev <= button_sync;
    end
  end

  assign ctl.button = button_sync && !button_prev;

  ring_b_edge_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (pin_prev[1] && !pin_sync[1])
    |=> wake_status_first[bit_ring_b]
  ) else $error("ring b edge lost");
  mouse_edge_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (pin_prev[3] && !pin_sync[3])
    |=> wake_status_first[bit_mouse_clock]
  ) else $error("mouse edge lost");
  button_pulse_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    ctl.button
    |=> !ctl.button
  ) else $error("button press longer than one cycle");

  // Falling edges on pins plus the alarm level; group irqs are excluded
  always_comb begin
    next_latched = pin_to_status(pin_prev & ~pin_sync);
    next_latched[bit_alarm] = clock_alarm_in;
  end

  // Set beats read-clear so a coincident edge survives
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wake_status_first <= rst_status_first;
    end else if (status_read) begin
      wake_status_first <= next_latched & latched_mask;
    end else begin
      wake_status_first <= (wake_status_first | next_latched) & latched_mask;
    end
  end

  always_comb begin
    status_view = wake_status_first;
    status_view[bit_group_a] = group_irq_a_in;
    status_view[bit_group_b] = group_irq_b_in;
  end

  clear_only_read_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !status_read
    |=> ((wake_status_first & $past(wake_status_first)) == $past(wake_status_first))
  ) else $error("status bit cleared without a read");
  coincide_keep_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    status_read
    |=> ((wake_status_first & $past(next_latched & latched_mask)) == $past(next_latched & latched_mask))
  ) else $error("edge lost under a clearing read");
  alarm_clear_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (status_read && !clock_alarm_in)
    |=> !wake_status_first[bit_alarm]
  ) else $error("alarm not cleared by read");

  // One process per register keeps each write path easy to trace
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wake_enable_first <= rst_enable_first;
    end else if (reg_wr_in && addr_hit(reg_addr_in, addr_enable_first)) begin
      wake_enable_first <= reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctl.enable_second <= rst_enable_second;
    end else if (reg_wr_in && addr_hit(reg_addr_in, addr_enable_second)) begin
      ctl.enable_second <= reg_wdata_in;
    end
  end

  // Bits 7:6 of the delay setting are reserved and always read zero
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctl.off_delay <= rst_off_delay;
    end else if (reg_wr_in && addr_hit(reg_addr_in, addr_off_delay)) begin
      ctl.off_delay <= reg_wdata_in & 8'h3f;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_mask <= rst_irq_mask;
    end else if (reg_wr_in && addr_hit(reg_addr_in, addr_irq_mask)) begin
      irq_mask <= reg_wdata_in;
    end
  end

  enable_write_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (reg_wr_in && addr_hit(reg_addr_in, addr_enable_first))
    |=> (wake_enable_first == $past(reg_wdata_in))
  ) else $error("enable write not taken");
  enable_hold_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !(reg_wr_in && addr_hit(reg_addr_in, addr_enable_first))
    |=> $stable(wake_enable_first)
  ) else $error("enable changed without a write");
  off_delay_mask_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ctl.off_delay[7] == 1'b0)
    && (ctl.off_delay[6] == 1'b0)
  ) else $error("reserved delay bits set");

  assign ctl.enable_first = wake_enable_first;

  // Power request: any status bit with its enable
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      power_up_request_n_out <= 1'b1;
    end else begin
      power_up_request_n_out <= ~|(status_view & wake_enable_first);
    end
  end

  no_source_idle_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !(|(status_view & wake_enable_first))
    |=> power_up_request_n_out
  ) else $error("request without an enabled source");
  request_reset_a: assert property (
    @(posedge core_clk_in)
    sys_rst_in
    |=> power_up_request_n_out
  ) else $error("request active after reset");

  // Interrupt: sticky copy of status events, cleared by a status read
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_status <= 8'h00;
    end else if (irq_read) begin
      irq_status <= next_latched | {2'b00, group_irq_b_in, group_irq_a_in, 4'h0};
    end else begin
      irq_status <= irq_status | next_latched | {2'b00, group_irq_b_in, group_irq_a_in, 4'h0};
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  irq_sets_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (|(next_latched & irq_mask))
    |=> irq_out
  ) else $error("unmasked event gave no interrupt");
  irq_clear_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (irq_read && (next_latched == 8'h00) && !group_irq_a_in && !group_irq_b_in)
    |=> !irq_out
  ) else $error("interrupt not cleared by read");

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        addr_enable_first:  reg_rdata_out <= wake_enable_first;
        addr_enable_second: reg_rdata_out <= ctl.enable_second;
        addr_status_first:  reg_rdata_out <= status_view;
        addr_irq_mask:      reg_rdata_out <= irq_mask;
        addr_off_delay:     reg_rdata_out <= ctl.off_delay;
        default:            reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  rdata_idle_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !reg_rd_in
    |=> (reg_rdata_out == 8'h00)
  ) else $error("read data outside a read");
  status_readback_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    status_read
    |=> (reg_rdata_out == $past(status_view))
  ) else $error("status read data wrong");
  group_readback_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    status_read
    |=> ({reg_rdata_out[bit_group_b], reg_rdata_out[bit_group_a]} == $past({group_irq_b_in, group_irq_a_in}))
  ) else $error("group bits not live");
  unmapped_zero_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (reg_rd_in && !addr_mapped(reg_addr_in))
    |=> (reg_rdata_out == 8'h00)
  ) else $error("unmapped read not zero");
  delay_end_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    ctl.delay_done
    |-> !ctl.delay_busy
  ) else $error("delay done while busy");

  assign off_delay_done_out = ctl.delay_done;

  off_delay_timer #(
    .step_count (step_count)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .ctl         (ctl)
  );

  request_follows_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (|(status_view & wake_enable_first))
    |=> !power_up_request_n_out
  ) else $error("request missing");
  disabled_blocks_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (wake_enable_first == 8'h00)
    |=> power_up_request_n_out
  ) else $error("disabled source woke");
  ring_edge_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (pin_prev[0] && !pin_sync[0])
    |=> wake_status_first[bit_ring_a]
  ) else $error("ring edge lost");
  kbd_edge_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (pin_prev[2] && !pin_sync[2])
    |=> wake_status_first[bit_kbd_clock]
  ) else $error("kbd edge lost");
  infrared_edge_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (pin_prev[4] && !pin_sync[4])
    |=> wake_status_first[bit_infrared]
  ) else $error("ir edge lost");
  alarm_latch_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    clock_alarm_in
    |=> wake_status_first[bit_alarm]
  ) else $error("alarm not latched");
  read_clears_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (status_read && next_latched == 8'h00)
    |=> (wake_status_first == 8'h00)
  ) else $error("read did not clear");
  group_direct_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (status_view[bit_group_a] == group_irq_a_in)
    && !wake_status_first[bit_group_b]
  ) else $error("group bit");
  hold_status_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (wake_status_first[bit_ring_b] && !status_read)
    |=> wake_status_first[bit_ring_b]
  ) else $error("bit lost");
  off_reset_a: assert property (
    @(posedge core_clk_in)
    sys_rst_in
    |=> ctl.enable_second[bit_off_enable]
  ) else $error("off enable reset wrong");
endmodule // soft_power_wake_events
`default_nettype wire

// [power_supply_model.sv]
`timescale 1ns/10ps
`default_nettype none
module power_supply_model (
  input  wire logic clk_in,        // Core clock
  input  wire logic rst_in,        // Sync reset
  input  wire logic request_n_in,  // Power-on request
  output logic      power_good_out // Rails up
);
  logic [1:0] settle;
  // Rails need two steady cycles of request before they report good
  always_ff @(posedge clk_in) begin
    if (rst_in || request_n_in)
      settle <= 2'h0;
    else if (settle != 2'h2)
      settle <= settle + 2'h1;
  end
  assign power_good_out = (settle == 2'h2);
endmodule // power_supply_model
`default_nettype wire

// [soft_power_wake_events_test.sv]
`timescale 1ns/10ps
`default_nettype none
module soft_power_wake_events_test;
  import wake_pkg::*;
  localparam int step_n = 10;
  logic       clk, rst, wr, rd, alarm, grp_a, grp_b, button;
  logic       req_n, done, irq, good;
  logic [7:0] addr, wdata, rdata, rdv, r1;
  logic [4:0] pins;
  int         fails, compares, n;
  int         pin_bit [5] = '{0, 1, 2, 3, 6};

  soft_power_wake_events #(.step_count(step_n)) uut (
    .core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .ring_event_a_in(pins[0]), .ring_event_b_in(pins[1]), .kbd_clock_event_in(pins[2]),
    .mouse_clock_event_in(pins[3]), .infrared_rx_event_in(pins[4]), .clock_alarm_in(alarm),
    .group_irq_a_in(grp_a), .group_irq_b_in(grp_b), .power_button_in(button),
    .power_up_request_n_out(req_n), .off_delay_done_out(done), .irq_out(irq));

  power_supply_model ps (.clk_in(clk), .rst_in(rst), .request_n_in(req_n), .power_good_out(good));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rdv = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rdr(a);
    chk(rdv, exp);
  endtask
  // Pin pulses low for one cycle, long enough for the synchroniser
  task automatic fall(input int i);
    @(posedge clk);
    pins[i] <= 1'b0;
    @(posedge clk);
    pins[i] <= 1'b1;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    {rst, wr, rd, alarm, grp_a, grp_b, button} = 7'b1000000;
    {addr, wdata, pins} = '0;
    pins = 5'h1f;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(addr_enable_first, rst_enable_first);
    rdc(addr_enable_second, rst_enable_second);
    rdc(addr_status_first, rst_status_first);
    rdc(8'h10, 8'h00);
    chk({7'h0, req_n}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wrt(addr_enable_first, 8'h01 << pin_bit[i]);
      fall(i);
      idle(5);
      chk({7'h0, req_n}, 8'h00);
      rdc(addr_status_first, 8'h01 << pin_bit[i]);
      rdc(addr_status_first, 8'h00);
      idle(2);
      chk({7'h0, req_n}, 8'h01);
    end
    wrt(addr_enable_first, 8'h7f);
    @(posedge clk);
    alarm <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    idle(4);
    chk({7'h0, req_n}, 8'h01);
    rdc(addr_status_first, 8'h80);
    wrt(addr_enable_first, 8'h80);
    alarm <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    idle(6);
    chk({6'h0, good, req_n}, 8'h02);
    rdc(addr_status_first, 8'h80);
    rdc(addr_status_first, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wrt(addr_enable_first, 8'h10 << j);
      {grp_b, grp_a} <= 2'b01 << j;
      idle(3);
      rdc(addr_status_first, 8'h10 << j);
      rdc(addr_status_first, 8'h10 << j);
      chk({7'h0, req_n}, 8'h00);
      {grp_b, grp_a} <= 2'b00;
      idle(2);
      rdc(addr_status_first, 8'h00);
    end
    rdr(addr_status_first);
    wrt(addr_irq_mask, 8'h04);
    rdc(addr_irq_mask, 8'h04);
    fall(3);
    idle(5);
    chk({7'h0, irq}, 8'h00);
    fall(2);
    idle(5);
    chk({7'h0, irq}, 8'h01);
    rdr(addr_status_first);
    idle(1);
    chk({7'h0, irq}, 8'h00);
    // Slide the read across the capture edge so one pass coincides
    for (int k = 0; k < 3; k++) begin
      fall(1);
      repeat (k) @(posedge clk);
      rdr(addr_status_first);
      r1 = rdv;
      rdr(addr_status_first);
      chk((r1 | rdv) & 8'h02, 8'h02);
    end
    wrt(addr_off_delay, 8'hff);
    rdc(addr_off_delay, 8'h3f);
    wrt(addr_off_delay, 8'h01);
    wrt(addr_enable_second, 8'hc0);
    button <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(n >= 2 * step_n && n <= 2 * step_n + 4), 8'h01);
    button <= 1'b0;
    idle(1);
    chk({7'h0, done}, 8'h00);
    // A second reset in mid-run must bring back the power-up defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(addr_enable_second, rst_enable_second);
    rdc(addr_off_delay, rst_off_delay);
    chk({7'h0, req_n}, 8'h01);
    give_verdict();
  end
endmodule // soft_power_wake_events_test
`default_nettype wire
